// file: gpio_group1_board.sv
`timescale 1ns/1ns
module gpio_group1_board (
  input wire logic [gpio_group1_pkg::NUM_PINS-1:0] pin_out, // design drive value
  input wire logic [gpio_group1_pkg::NUM_PINS-1:0] pin_oe, // design drive enable
  input wire logic [gpio_group1_pkg::NUM_PINS-1:0] ext_drive, // board drives line
  input wire logic [gpio_group1_pkg::NUM_PINS-1:0] ext_level, // board level
  output logic [gpio_group1_pkg::NUM_PINS-1:0] wire_level // resolved line
);
  import gpio_group1_pkg::*;
  // ----
  // lines have pull-ups: a released open-collector pin reads high
  // ----
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++)
      wire_level[i] = pin_oe[i] ? pin_out[i] : (ext_drive[i] ? ext_level[i] : 1'b1);
  end
endmodule

// file: gpio_group1_monitor.sv
`timescale 1ns/1ns
module gpio_group1_monitor (
  input wire logic CLOCK, // clock
  input wire logic SRST, // reset
  input wire logic HSEL, // select
  input wire logic [31:0] HADDR, // address
  input wire logic [1:0] HTRANS, // transfer
  input wire logic HWRITE, // write
  input wire logic [31:0] HWDATA, // wdata
  input wire logic HREADY, // ready in
  input wire logic HREADYOUT, // ready out
  input wire logic HRESP, // response
  input wire logic [gpio_group1_pkg::NUM_PINS-1:0] GPIO_OUT, // drive value
  input wire logic [gpio_group1_pkg::NUM_PINS-1:0] GPIO_OE, // drive enable
  input wire logic HOST_IO_VALID, // host cycle
  input wire logic [15:0] HOST_IO_ADDR, // host address
  input wire logic [15:0] IRQ_LINES, // steered irqs
  input wire logic COMBINED_IRQ1, // combined one
  input wire logic COMBINED_IRQ2, // combined two
  input wire logic INTERRUPT // status irq
);
  import gpio_group1_pkg::*;
  // ----
  // shadow of config and decode registers, fed by bus writes
  // ----
  logic [7:0] cfg [NUM_PINS];
  logic [15:0] dec;
  logic wr_pend;
  logic [7:0] wr_idx;
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wr_pend <= 1'b0;
      dec <= 16'h0;
      for (int i = 0; i < NUM_PINS; i++)
        cfg[i] <= CONFIG_RESET;
    end else begin
      wr_pend <= HSEL && HTRANS[1] && HREADY && HWRITE;
      wr_idx <= HADDR[9:2];
      if (wr_pend && wr_idx >= IDX_PIN_1_0_CONFIG && wr_idx <= IDX_PIN_1_5_CONFIG)
        cfg[wr_idx[2:0]] <= HWDATA[7:0];
      if (wr_pend && wr_idx == IDX_DECODE_ADDR)
        dec <= HWDATA[15:0];
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_resp_okay: assert property (HRESP == 1'b0) else $error("response not okay");
  a_read_wait: assert property (HSEL && HTRANS[1] && HREADY && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read not one wait state");
  a_write_nowait: assert property (HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  a_reset_quiet: assert property (disable iff (1'b0) SRST |=> GPIO_OE == '0 && !INTERRUPT && IRQ_LINES == 16'h0 && !COMBINED_IRQ1)
    else $error("outputs not quiet after reset");
  a_irq_unused: assert property (!IRQ_LINES[0] && !IRQ_LINES[2])
    else $error("disabled or invalid irq driven");
  a_comb2_off: assert property (!COMBINED_IRQ2)
    else $error("combined two raised");
  a_decode_out: assert property ($past(cfg[4][3]) |-> GPIO_OE[4] && GPIO_OUT[4] == ($past(HOST_IO_ADDR != dec || !HOST_IO_VALID) ^ $past(cfg[4][1])))
    else $error("decode output wrong");
  a_dir_input: assert property ($past(cfg[3][0] && !cfg[3][3]) |-> !GPIO_OE[3])
    else $error("input pin driven");
  c_read: cover property (HSEL && HTRANS[1] && !HWRITE ##1 !HREADYOUT);
  c_decode: cover property ($past(cfg[4][3]) && !GPIO_OUT[4]);
  c_irq: cover property (INTERRUPT && IRQ_LINES[15]);
endmodule

// file: gpio_group1_pin_config.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module gpio_group1_pin_config (
  input wire logic CLOCK, // 250 MHz clock
  input wire logic SRST, // synchronous reset, active high
  input wire logic HSEL, // ahb slave select
  input wire logic [31:0] HADDR, // ahb address
  input wire logic [1:0] HTRANS, // ahb transfer type
  input wire logic HWRITE, // ahb write
  input wire logic [2:0] HSIZE, // ahb size, word only
  input wire logic [31:0] HWDATA, // ahb write data
  input wire logic HREADY, // ahb bus ready
  output logic HREADYOUT, // ahb slave ready
  output logic HRESP, // ahb response, always okay
  output logic [31:0] HRDATA, // ahb read data
  input wire logic [gpio_group1_pkg::NUM_PINS-1:0] GPIO_IN, // pin levels, asynchronous
  output logic [gpio_group1_pkg::NUM_PINS-1:0] GPIO_OUT, // pin drive value
  output logic [gpio_group1_pkg::NUM_PINS-1:0] GPIO_OE, // pin drive enable
  input wire logic WATCHDOG_TIMEOUT, // watchdog timeout level
  input wire logic POWER_LED, // power led level
  input wire logic INFRARED_TRANSMIT, // infrared transmit data
  input wire logic SYSTEM_IRQ13, // irq13 level to drive out on pin 1.1
  input wire logic HOST_IO_VALID, // host io cycle in progress
  input wire logic HOST_IO_WRITE, // host io cycle is a write
  input wire logic [15:0] HOST_IO_ADDR, // host io address
  output logic INFRARED_RECEIVE_INPUT, // infrared receive data from pin 1.2
  output logic [15:0] IRQ_LINES, // steered interrupt lines
  output logic COMBINED_IRQ1, // combined interrupt one
  output logic COMBINED_IRQ2, // combined interrupt two
  output logic INTERRUPT // enabled sticky status pending
);
  import gpio_group1_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pin_config_s cfg_reg [NUM_PINS];
  logic [NUM_PINS-1:0] pin_data_reg;
  logic [7:0] ir_options_reg;
  logic [15:0] decode_addr_reg;
  logic [IRQ_EVENTS-1:0] irq_status_reg;
  logic [IRQ_EVENTS-1:0] irq_status_next;
  logic [IRQ_EVENTS-1:0] irq_enable_reg;
  logic [IRQ_EVENTS-1:0] irq_events;
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic [NUM_PINS-1:0] in_adj;
  logic [NUM_PINS-1:0] in_adj_prev_reg;
  logic [NUM_PINS-1:0] alt_drive;
  logic [NUM_PINS-1:0] alt_value;
  logic [NUM_PINS-1:0] open_coll;
  logic [NUM_PINS-1:0] alt_input;
  logic [NUM_PINS-1:0] pin_value;
  logic [NUM_PINS-1:0] pin_drive;
  logic [NUM_PINS-1:0] ie1_vec;
  logic [NUM_PINS-1:0] ie2_vec;
  logic combined1;
  logic combined2;
  logic combined1_prev_reg;
  logic combined2_prev_reg;
  logic [15:0] steer0;
  logic [15:0] steer1;
  logic decode_hit;
  logic write_hit;
  logic ir_mode;
  bus_state_e bus_state_reg;
  bus_req_s req_reg;
  logic addr_phase;
  logic wr_en;
  logic [31:0] rd_mux;
  logic [7:0] wmask [NUM_PINS];

  // ----------------------------------------------------------------
  // interrupt steering decode
  // ----------------------------------------------------------------
  function automatic logic [15:0] steer_decode(input logic [3:0] code, input logic [3:0] top_line);
    logic [15:0] onehot;
    onehot = '0;
    if (code == MAP_DISABLE || code == MAP_INVALID) begin // see R08
      onehot = '0;
    end else if (code == MAP_TOP) begin
      onehot[top_line] = 1'b1; // see R08
    end else begin
      onehot[code] = 1'b1; // see R09
    end
    return onehot;
  endfunction

  // ----------------------------------------------------------------
  // pin input synchronisers and polarity
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= GPIO_IN;
      sync2_reg <= sync1_reg;
    end
  end

  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin_in
      assign in_adj[i] = sync2_reg[i] ^ cfg_reg[i].invert; // see R02
      assign ie1_vec[i] = cfg_reg[i].int_en1; // see R03
      assign ie2_vec[i] = cfg_reg[i].int_en2 & GENERIC_LAYOUT[i]; // see R05
      assign wmask[i] = (i < 2) ? WMASK_FULL : WMASK_LOW; // see R17
    end
  endgenerate

  assign combined1 = |(in_adj & ie1_vec); // see R18
  assign combined2 = |(in_adj & ie2_vec); // see R18
  assign ir_mode = ir_options_reg[IR_SELECT_BIT];

  // ----------------------------------------------------------------
  // alternate functions per pin
  // ----------------------------------------------------------------
  always_comb begin
    alt_drive = '0;
    alt_value = '0;
    open_coll = '0;
    alt_input = '0;
    steer0 = '0;
    steer1 = '0;
    // pin 1.0: input steering
    if (cfg_reg[0].func_sel[0] && cfg_reg[0].is_input) begin
      steer0 = steer_decode({cfg_reg[0].open_collector, cfg_reg[0].int_en2, cfg_reg[0].reserved5,
                             cfg_reg[0].func_sel[1]}, MAP_TOP); // see R07
    end
    // pin 1.1: gpio, irq13 drive or interrupt input
    if (cfg_reg[1].func_sel[0]) begin
      steer1 = steer_decode({cfg_reg[1].open_collector, cfg_reg[1].int_en2, cfg_reg[1].reserved5,
                             cfg_reg[1].func_sel[1]}, PIN11_TOP_IRQ); // see R11 R12
    end else if (cfg_reg[1].func_sel[1]) begin
      if (cfg_reg[1].open_collector) begin
        alt_drive[1] = 1'b1; // see R10
        alt_value[1] = SYSTEM_IRQ13;
        open_coll[1] = 1'b1;
      end
    end else begin
      open_coll[1] = cfg_reg[1].open_collector; // see R10 R06
    end
    // pin 1.2: watchdog out, or infrared receive in
    if (cfg_reg[2].func_sel[0] && !ir_mode) begin
      alt_drive[2] = 1'b1; // see R13
      alt_value[2] = WATCHDOG_TIMEOUT;
    end else if (cfg_reg[2].func_sel[0]) begin
      // infrared receive is an input: the pin is released whatever bit 0 says
      alt_input[2] = 1'b1; // see R13
    end
    // pin 1.3: power led or infrared transmit
    if (cfg_reg[3].func_sel[0]) begin
      alt_drive[3] = 1'b1; // see R14
      alt_value[3] = ir_mode ? INFRARED_TRANSMIT : POWER_LED;
    end
    // pin 1.4: active-low address decode
    if (cfg_reg[4].func_sel[0]) begin
      alt_drive[4] = 1'b1; // see R15
      alt_value[4] = ~decode_hit;
    end
    // pin 1.5: active-low write strobe
    if (cfg_reg[5].func_sel[0]) begin
      alt_drive[5] = 1'b1; // see R16
      alt_value[5] = ~write_hit;
    end
  end

  assign decode_hit = HOST_IO_VALID && (HOST_IO_ADDR == decode_addr_reg);
  assign write_hit = decode_hit && HOST_IO_WRITE;

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin_out
      assign pin_value[i] = (alt_drive[i] ? alt_value[i] : pin_data_reg[i]) ^ cfg_reg[i].invert; // see R02
      assign pin_drive[i] = alt_drive[i] | (~cfg_reg[i].is_input & ~alt_input[i]); // see R01
    end
  endgenerate

  // open-collector pins never drive high: they only pull low or let go
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      GPIO_OUT <= '0;
      GPIO_OE <= '0;
    end else begin
      GPIO_OUT <= pin_value & ~open_coll; // see R06
      GPIO_OE <= pin_drive & ~(open_coll & pin_value);
    end
  end

  // ----------------------------------------------------------------
  // interrupt and infrared outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      IRQ_LINES <= '0;
      COMBINED_IRQ1 <= 1'b0;
      COMBINED_IRQ2 <= 1'b0;
      INFRARED_RECEIVE_INPUT <= 1'b0;
    end else begin
      // steered lines carry the polarity-adjusted pin level, not just the selection
      IRQ_LINES <= (steer0 & {16{in_adj[0]}}) | (steer1 & {16{in_adj[1]}}); // see R07 R11
      COMBINED_IRQ1 <= combined1;
      COMBINED_IRQ2 <= combined2;
      INFRARED_RECEIVE_INPUT <= cfg_reg[2].func_sel[0] & ir_mode & in_adj[2]; // see R13
    end
  end

  // ----------------------------------------------------------------
  // sticky status and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      in_adj_prev_reg <= '0;
      combined1_prev_reg <= 1'b0;
      combined2_prev_reg <= 1'b0;
    end else begin
      in_adj_prev_reg <= in_adj;
      combined1_prev_reg <= combined1;
      combined2_prev_reg <= combined2;
    end
  end

  always_comb begin
    irq_events = '0;
    irq_events[NUM_PINS-1:0] = in_adj & ~in_adj_prev_reg & ie1_vec;
    irq_events[EV_COMBINED1] = combined1 & ~combined1_prev_reg;
    irq_events[EV_COMBINED2] = combined2 & ~combined2_prev_reg;
    irq_status_next = irq_status_reg;
    if (wr_en && req_reg.index == IDX_IRQ_CLEAR) begin
      irq_status_next = irq_status_next & ~HWDATA[IRQ_EVENTS-1:0];
    end
    // a new event wins over a clear in the same cycle
    irq_status_next = irq_status_next | irq_events;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      irq_status_reg <= '0;
      INTERRUPT <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      INTERRUPT <= |(irq_status_next & irq_enable_reg);
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave: writes zero wait, reads one wait state
  // ----------------------------------------------------------------
  assign addr_phase = HSEL && HTRANS[1] && HREADY;
  assign wr_en = (bus_state_reg == BUS_WR_DATA) && req_reg.mapped;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      bus_state_reg <= BUS_IDLE;
      req_reg <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= '0;
    end else begin
      HRESP <= 1'b0;
      case (bus_state_reg)
        BUS_RD_WAIT: begin
          HRDATA <= req_reg.mapped ? rd_mux : 32'h0000_0000;
          HREADYOUT <= 1'b1;
          bus_state_reg <= BUS_IDLE;
        end
        BUS_IDLE, BUS_WR_DATA: begin
          if (addr_phase) begin
            req_reg.write <= HWRITE;
            req_reg.index <= HADDR[9:2];
            req_reg.mapped <= (HADDR[31:10] == '0) && (HADDR[1:0] == 2'h0);
            bus_state_reg <= HWRITE ? BUS_WR_DATA : BUS_RD_WAIT;
            HREADYOUT <= HWRITE;
          end else begin
            bus_state_reg <= BUS_IDLE;
            HREADYOUT <= 1'b1;
          end
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
          HREADYOUT <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = '0;
    case (req_reg.index)
      IDX_PIN_1_0_CONFIG: rd_mux[7:0] = cfg_reg[0];
      IDX_PIN_1_1_CONFIG: rd_mux[7:0] = cfg_reg[1];
      IDX_PIN_1_2_CONFIG: rd_mux[7:0] = cfg_reg[2];
      IDX_PIN_1_3_CONFIG: rd_mux[7:0] = cfg_reg[3];
      IDX_PIN_1_4_CONFIG: rd_mux[7:0] = cfg_reg[4];
      IDX_PIN_1_5_CONFIG: rd_mux[7:0] = cfg_reg[5];
      IDX_PIN_DATA: rd_mux[NUM_PINS-1:0] = in_adj;
      IDX_IR_OPTIONS: rd_mux[7:0] = ir_options_reg;
      IDX_DECODE_ADDR: rd_mux[15:0] = decode_addr_reg;
      IDX_IRQ_STATUS: rd_mux[IRQ_EVENTS-1:0] = irq_status_reg;
      IDX_IRQ_ENABLE: rd_mux[IRQ_EVENTS-1:0] = irq_enable_reg;
      default: rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_cfg
      always_ff @(posedge CLOCK) begin
        if (SRST) begin
          cfg_reg[i] <= CONFIG_RESET;
        end else if (wr_en && req_reg.index == IDX_PIN_1_0_CONFIG + 8'(i)) begin
          cfg_reg[i] <= HWDATA[7:0] & wmask[i]; // see R04 R17
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pin_data_reg <= '0;
      ir_options_reg <= '0;
      decode_addr_reg <= '0;
      irq_enable_reg <= '0;
    end else if (wr_en) begin
      case (req_reg.index)
        IDX_PIN_DATA: pin_data_reg <= HWDATA[NUM_PINS-1:0];
        IDX_IR_OPTIONS: ir_options_reg <= HWDATA[7:0];
        IDX_DECODE_ADDR: decode_addr_reg <= HWDATA[15:0];
        IDX_IRQ_ENABLE: irq_enable_reg <= HWDATA[IRQ_EVENTS-1:0];
        default: ir_options_reg <= ir_options_reg;
      endcase
    end
  end

endmodule

// file: gpio_group1_pkg.sv
// How it works
// R01: config bit 0 high makes the pin an input, low an output.
// R02: config bit 1 high inverts the value between pin and logic.
// R03: config bit 2 high lets the pin feed combined interrupt one.
// R04: generic bits 4:3 pick original or alternate functions one to three.
// R05: generic bit 6 feeds combined interrupt two; bit 5 is reserved.
// R06: generic bit 7 high gives open-collector drive, low gives push-pull.
// R07: pin 1.0 bit 3 steers its input to the interrupt picked by bits 7:4.
// R08: pin 1.0 code 0000 disables, 0001 IRQ1, 0010 invalid, 0011 IRQ3, 1111 IRQ15.
// R09: pin 1.0 codes 0100 to 1110 pick the interrupt of that number.
// R10: pin 1.1 bits 4:3 clear is GPIO with bit 7 drive type; 1,1,0 drives IRQ13.
// R11: pin 1.1 bit 3 set is interrupt input, push-pull, target from bits 7:4.
// R12: pin 1.1 pattern 00101 on bits 7:3 is reserved and steers nothing.
// R13: pin 1.2 alternate is watchdog output, or infrared receive when IR bit 6 set.
// R14: pin 1.3 alternate is power LED, or infrared transmit when IR bit 6 set.
// R15: pin 1.4 alternate is active-low address decode of a two-byte address.
// R16: pin 1.5 alternate is active-low write strobe output.
// R17: software writes zero to upper four bits of pins 1.2-1.5; they read zero.
// R18: each combined interrupt is the OR of enabled polarity-adjusted inputs.
package gpio_group1_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PIN_1_0_CONFIG = 8'he0;
  localparam logic [7:0] IDX_PIN_1_1_CONFIG = 8'he1;
  localparam logic [7:0] IDX_PIN_1_2_CONFIG = 8'he2;
  localparam logic [7:0] IDX_PIN_1_3_CONFIG = 8'he3;
  localparam logic [7:0] IDX_PIN_1_4_CONFIG = 8'he4;
  localparam logic [7:0] IDX_PIN_1_5_CONFIG = 8'he5;
  localparam logic [7:0] IDX_PIN_DATA = 8'hf0;
  localparam logic [7:0] IDX_IR_OPTIONS = 8'hf1;
  localparam logic [7:0] IDX_DECODE_ADDR = 8'hf2;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hf3;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hf4;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hf5;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 6;
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] WMASK_LOW = 8'h0f;
  localparam int IR_SELECT_BIT = 6;
  localparam logic [1:0] FSEL_ORIGINAL = 2'h0;
  localparam logic [1:0] FSEL_ALT1 = 2'h1;
  localparam logic [1:0] FSEL_ALT2 = 2'h2;
  localparam logic [3:0] MAP_DISABLE = 4'h0;
  localparam logic [3:0] MAP_INVALID = 4'h2;
  localparam logic [3:0] MAP_TOP = 4'hf;
  localparam logic [3:0] PIN11_TOP_IRQ = 4'he;
  localparam int PIN11_OC_IRQ = 13;
  localparam int IRQ_EVENTS = 8;
  localparam int EV_COMBINED1 = 6;
  localparam int EV_COMBINED2 = 7;
  // pins whose config follows the generic layout for bits 7:5
  localparam logic [NUM_PINS-1:0] GENERIC_LAYOUT = 6'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic open_collector;
    logic int_en2;
    logic reserved5;
    logic [1:0] func_sel;
    logic int_en1;
    logic invert;
    logic is_input;
  } pin_config_s;

  typedef struct packed {
    logic write;
    logic [7:0] index;
    logic mapped;
  } bus_req_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD_WAIT = 2'b01,
    BUS_WR_DATA = 2'b11
  } bus_state_e;

endpackage

// file: tb.sv
`timescale 1ns/1ns
module tb;
  import gpio_group1_pkg::*;
  logic clock = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, wdt = 1'b0, led = 1'b0;
  logic infrared_transmit_output = 1'b0, irq13 = 1'b0, hv = 1'b0, hw = 1'b0, rdy, hresp, infrared_receive_input, c1, c2, intr;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [5:0] gin, gout, goe, xdrv = 6'h0, xlvl = 6'h0;
  logic [15:0] ha = 16'h0, irql;
  logic [31:0] rows [8][3] = '{'{32'he0, 32'hff, 32'hff}, '{32'he1, 32'ha5, 32'ha5},
    '{32'he2, 32'h0e, 32'h0e}, '{32'he3, 32'h0a, 32'h0a}, '{32'he4, 32'h05, 32'h05},
    '{32'he5, 32'h03, 32'h03}, '{32'hf2, 32'h1234, 32'h1234}, '{32'he6, 32'hff, 32'h0}};
  logic [3:0] pc [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
  logic [15:0] pe [5] = '{16'h0, 16'h2, 16'h0, 16'h8, 16'h4000};
  int n_errors = 0, cmp_count = 0;
  gpio_group1_pin_config DUT (.CLOCK(clock), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(rdy), .HREADYOUT(rdy), .HRESP(hresp),
    .HRDATA(hrdata), .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE(goe), .WATCHDOG_TIMEOUT(wdt),
    .POWER_LED(led), .INFRARED_TRANSMIT(infrared_transmit_output), .SYSTEM_IRQ13(irq13), .HOST_IO_VALID(hv),
    .HOST_IO_WRITE(hw), .HOST_IO_ADDR(ha), .INFRARED_RECEIVE_INPUT(infrared_receive_input), .IRQ_LINES(irql),
    .COMBINED_IRQ1(c1), .COMBINED_IRQ2(c2), .INTERRUPT(intr));
  gpio_group1_board board (.pin_out(gout), .pin_oe(goe), .ext_drive(xdrv), .ext_level(xlvl),
    .wire_level(gin));
  initial begin
    forever #2 clock = ~clock;
  end
  // ----
  // tasks
  // ----
  task automatic results;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic rst;
    srst <= 1'b1;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
  endtask
  // waits for as long as the slave stalls; only the watchdog ends a hang
  task automatic rdy_wait;
    do begin
      @(posedge clock);
    end while (rdy !== 1'b1);
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    rdy_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, r);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0, r);
    chk("read", e, r);
  endtask
  // pin path is two sync flops plus one output flop
  task automatic wt;
    repeat (4) @(posedge clock);
  endtask
  task automatic pin(input int i, input logic e_oe, e_out);
    chkb("oe", e_oe, goe[i]);
    chkb("out", e_out, gout[i]);
  endtask
  task automatic io(input logic v, w, input logic [15:0] a);
    hv <= v;
    hw <= w;
    ha <= a;
    wt();
  endtask
  initial begin
    #100000;
    n_errors++;
    results();
  end
  // ----
  // tests
  // ----
  initial begin
    rst();
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][0][7:0], rows[i][1]);
      rdc(rows[i][0][7:0], rows[i][2]);
    end
    rst();
    for (int i = 0; i < NUM_PINS; i++)
      rdc(IDX_PIN_1_0_CONFIG + 8'(i), 32'(CONFIG_RESET));
    chk("oe", 32'h0, 32'(goe));
    wr(IDX_PIN_DATA, 32'h08);
    wr(IDX_PIN_1_3_CONFIG, 32'h00);
    wt();
    pin(3, 1'b1, 1'b1);
    wr(IDX_PIN_1_3_CONFIG, 32'h02);
    wt();
    pin(3, 1'b1, 1'b0);
    xdrv[2] <= 1'b1;
    xlvl[2] <= 1'b1;
    wr(IDX_PIN_1_2_CONFIG, 32'h07);
    wt();
    bus(1'b0, IDX_PIN_DATA, 32'h0, r);
    chkb("in2", 1'b0, r[2]);
    wr(IDX_IRQ_ENABLE, 32'h40);
    wr(IDX_PIN_1_2_CONFIG, 32'h05);
    wt();
    chkb("comb1", 1'b1, c1);
    chkb("irq", 1'b1, intr);
    rdc(IDX_IRQ_STATUS, 32'h44);
    wr(IDX_IRQ_ENABLE, 32'h0);
    wt();
    chkb("irq", 1'b0, intr);
    wr(IDX_IRQ_CLEAR, 32'h44);
    rdc(IDX_IRQ_STATUS, 32'h0);
    wr(IDX_IRQ_ENABLE, 32'h40);
    xlvl[2] <= 1'b0;
    wt();
    chkb("irq", 1'b0, intr);
    chkb("comb1", 1'b0, c1);
    wr(IDX_PIN_1_2_CONFIG, 32'h01);
    xlvl[2] <= 1'b1;
    wt();
    chkb("comb1", 1'b0, c1);
    xdrv[1:0] <= 2'h3;
    xlvl[1:0] <= 2'h3;
    for (int c = 0; c < 16; c++) begin
      wr(IDX_PIN_1_0_CONFIG, {24'h0, c[3:0], 4'h9});
      wt();
      chk("steer", (c == 0 || c == 2) ? 32'h0 : 32'h1 << c, 32'(irql));
    end
    xlvl[0] <= 1'b0;
    wt();
    chk("steer", 32'h0, 32'(irql));
    wr(IDX_PIN_1_0_CONFIG, 32'h38);
    wt();
    chk("steer", 32'h0, 32'(irql));
    wr(IDX_PIN_1_0_CONFIG, 32'h01);
    for (int i = 0; i < 5; i++) begin
      wr(IDX_PIN_1_1_CONFIG, {24'h0, pc[i], 4'h9});
      wt();
      chk("interrupt_input_mode", 32'(pe[i]), 32'(irql));
    end
    xdrv[1] <= 1'b0;
    wr(IDX_PIN_1_1_CONFIG, 32'h91);
    wt();
    pin(1, 1'b1, 1'b0);
    irq13 <= 1'b1;
    wt();
    chkb("oe", 1'b0, goe[1]);
    wr(IDX_PIN_1_1_CONFIG, 32'h80);
    wt();
    pin(1, 1'b1, 1'b0);
    wr(IDX_PIN_DATA, 32'h0a);
    wt();
    chkb("oe", 1'b0, goe[1]);
    wdt <= 1'b1;
    wr(IDX_PIN_1_2_CONFIG, 32'h08);
    wt();
    pin(2, 1'b1, 1'b1);
    wr(IDX_IR_OPTIONS, 32'h40);
    wt();
    chkb("oe", 1'b0, goe[2]);
    chkb("infrared_receive_input", 1'b1, infrared_receive_input);
    xlvl[2] <= 1'b0;
    led <= 1'b1;
    wr(IDX_PIN_1_3_CONFIG, 32'h08);
    wt();
    chkb("infrared_receive_input", 1'b0, infrared_receive_input);
    pin(3, 1'b1, 1'b0);
    infrared_transmit_output <= 1'b1;
    wt();
    pin(3, 1'b1, 1'b1);
    led <= 1'b0;
    wr(IDX_IR_OPTIONS, 32'h0);
    wt();
    pin(3, 1'b1, 1'b0);
    wr(IDX_DECODE_ADDR, 32'h1234);
    wr(IDX_PIN_1_4_CONFIG, 32'h08);
    wr(IDX_PIN_1_5_CONFIG, 32'h08);
    io(1'b1, 1'b0, 16'h1234);
    pin(4, 1'b1, 1'b0);
    pin(5, 1'b1, 1'b1);
    io(1'b1, 1'b1, 16'h1234);
    pin(5, 1'b1, 1'b0);
    io(1'b1, 1'b1, 16'h1235);
    pin(4, 1'b1, 1'b1);
    io(1'b0, 1'b0, 16'h1234);
    pin(5, 1'b1, 1'b1);
    results();
  end
endmodule
bind gpio_group1_pin_config gpio_group1_monitor u_mon (.CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
  .HOST_IO_VALID(HOST_IO_VALID), .HOST_IO_ADDR(HOST_IO_ADDR), .IRQ_LINES(IRQ_LINES),
  .COMBINED_IRQ1(COMBINED_IRQ1), .COMBINED_IRQ2(COMBINED_IRQ2), .INTERRUPT(INTERRUPT));
